// [clo_listen_window.sv]
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module clo_listen_window (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        frame_valid,
  output logic             frame_ready,
  input  wire logic [10:0] frame_id,
  input  wire logic [3:0]  frame_dlc,
  input  wire logic [63:0] frame_data,
  input  wire logic        frame_error,
  input  wire logic        core_tx_bit,
  input  wire logic        tx_error_pulse,
  input  wire logic        rx_error_pulse,
  output logic             can_tx,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [10:0]      rx_id,
  output logic [3:0]       rx_dlc,
  output logic [63:0]      rx_data,
  output logic             rx_error
);
  localparam int FW = $bits(clo_pkg::clo_frame_type);

  // ==========================================
  // Storage
  logic [15:0] aw_addr_reg;
  logic        aw_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_hold_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [7:0]  mode_reg;
  logic [2:0]  op_mode_reg;
  logic [7:0]  ectrl_reg;
  logic [10:0] mask_reg;
  logic [3:0]  filt_sel_reg;
  logic [10:0] filt_reg [clo_pkg::NUM_FILT];
  logic [15:0] fen_reg;
  logic [7:0]  buf_reg [clo_pkg::NUM_BUF];
  logic [7:0]  tec_reg;
  logic [7:0]  rec_reg;
  logic        can_tx_reg;

  // ==========================================
  // Decoded signals
  logic                        wr_fire;
  logic [13:0]                 wr_idx;
  logic [13:0]                 rd_idx;
  logic [31:0]                 wr_word;
  logic                        wr_hit;
  logic [31:0]                 rd_word;
  logic                        rd_hit;
  logic                        listen;
  logic [1:0]                  emode;
  logic [4:0]                  wsel;
  logic                        win_on;
  logic [2:0]                  win_n;
  logic [clo_pkg::NUM_FILT-1:0] match;
  logic                        accept;
  logic [clo_pkg::NUM_BUF-1:0] buf_we;
  clo_pkg::clo_frame_type      in_frame;
  clo_pkg::clo_frame_type      out_frame;

  clo_stream_if #(.W(FW)) in_if ();
  clo_stream_if #(.W(FW)) out_if ();

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================
  // Mode and window decode
  assign listen = mode_reg[clo_pkg::MODE_REQ_LSB +: 3] == clo_pkg::MODE_LISTEN;
  assign emode  = ectrl_reg[clo_pkg::EMODE_LSB +: 2];
  assign wsel   = ectrl_reg[clo_pkg::EWSEL_LSB +: 5];
  assign win_on = (emode == clo_pkg::EMODE_ENH || emode == clo_pkg::EMODE_FIFO)
                  && wsel >= clo_pkg::WIN_BUF_FIRST && wsel <= clo_pkg::WIN_BUF_LAST;
  assign win_n  = 3'(wsel - clo_pkg::WIN_BUF_FIRST);

  // ==========================================
  // AXI write channel
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr_idx        = aw_addr_reg[15:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 16'h0000;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= clo_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? clo_pkg::RESP_OKAY : clo_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Write decode
  always_comb begin
    wr_hit  = 1'b1;
    buf_we  = '0;
    wr_word = 32'h0000_0000;
    case (wr_idx)
      clo_pkg::IDX_MODE:   wr_word = merge({24'h0, mode_reg}, w_data_reg, w_strb_reg);
      clo_pkg::IDX_ECTRL:  wr_word = merge({24'h0, ectrl_reg}, w_data_reg, w_strb_reg);
      clo_pkg::IDX_MASK:   wr_word = merge({21'h0, mask_reg}, w_data_reg, w_strb_reg);
      clo_pkg::IDX_FILT:   wr_word = w_data_reg;
      clo_pkg::IDX_FEN_LO: wr_word = merge({24'h0, fen_reg[7:0]}, w_data_reg, w_strb_reg);
      clo_pkg::IDX_FEN_HI: wr_word = merge({24'h0, fen_reg[15:8]}, w_data_reg, w_strb_reg);
      clo_pkg::IDX_STATUS,
      clo_pkg::IDX_ERRCNT: wr_word = 32'h0000_0000;
      clo_pkg::IDX_WINDOW: begin
        wr_word = merge({24'h0, buf_reg[win_n]}, w_data_reg, w_strb_reg);
        buf_we[win_n] = wr_fire & win_on;
      end
      default: begin
        if (wr_idx[13:3] == clo_pkg::IDX_BUF_HI && wr_idx[2:0] < 3'(clo_pkg::NUM_BUF)) begin
          wr_word = merge({24'h0, buf_reg[wr_idx[2:0]]}, w_data_reg, w_strb_reg);
          buf_we[wr_idx[2:0]] = wr_fire;
        end else begin
          wr_hit = 1'b0;
        end
      end
    endcase
  end

  // ==========================================
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg    <= clo_pkg::MODE_RST;
      op_mode_reg <= clo_pkg::MODE_RST[clo_pkg::MODE_REQ_LSB +: 3];
      ectrl_reg   <= clo_pkg::ECTRL_RST;
      mask_reg    <= clo_pkg::MASK_RST;
      fen_reg     <= {clo_pkg::FEN_HI_RST, clo_pkg::FEN_LO_RST};
      filt_sel_reg <= 4'h0;
    end else begin
      op_mode_reg <= mode_reg[clo_pkg::MODE_REQ_LSB +: 3];
      if (wr_fire) begin
        case (wr_idx)
          clo_pkg::IDX_MODE:   mode_reg <= wr_word[7:0];
          clo_pkg::IDX_ECTRL:  ectrl_reg <= wr_word[7:0];
          clo_pkg::IDX_MASK:   mask_reg <= wr_word[10:0];
          clo_pkg::IDX_FILT:   filt_sel_reg <= wr_word[clo_pkg::FILT_IDX_LSB +: 4];
          clo_pkg::IDX_FEN_LO: fen_reg[7:0] <= wr_word[7:0];
          clo_pkg::IDX_FEN_HI: fen_reg[15:8] <= wr_word[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================
  // Filters and buffer controls
  for (genvar i = 0; i < clo_pkg::NUM_FILT; i++) begin : g_filt
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        filt_reg[i] <= clo_pkg::FILT_RST;
      end else if (wr_fire && wr_idx == clo_pkg::IDX_FILT
                   && wr_word[clo_pkg::FILT_IDX_LSB +: 4] == 4'(i)) begin
        filt_reg[i] <= wr_word[10:0];
      end
    end
    assign match[i] = fen_reg[i] & (((frame_id ^ filt_reg[i]) & mask_reg) == 11'h000);
  end

  for (genvar n = 0; n < clo_pkg::NUM_BUF; n++) begin : g_buf
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        buf_reg[n] <= clo_pkg::BUF_RST;
      end else if (buf_we[n]) begin
        buf_reg[n] <= wr_word[7:0];
      end
    end
  end

  // ==========================================
  // AXI read channel
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_idx        = s_axi_araddr[15:2];

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (rd_idx)
      clo_pkg::IDX_MODE:   rd_word = {24'h0, mode_reg};
      clo_pkg::IDX_STATUS: rd_word = {24'h0, op_mode_reg, 5'h00};
      clo_pkg::IDX_ERRCNT: rd_word = {16'h0, rec_reg, tec_reg};
      clo_pkg::IDX_ECTRL:  rd_word = {24'h0, ectrl_reg};
      clo_pkg::IDX_MASK:   rd_word = {21'h0, mask_reg};
      clo_pkg::IDX_FILT:   rd_word = {4'h0, filt_sel_reg, 13'h0, filt_reg[filt_sel_reg]};
      clo_pkg::IDX_FEN_LO: rd_word = {24'h0, fen_reg[7:0]};
      clo_pkg::IDX_FEN_HI: rd_word = {24'h0, fen_reg[15:8]};
      clo_pkg::IDX_WINDOW: rd_word = win_on ? {24'h0, buf_reg[win_n]} : 32'h0000_0000;
      default: begin
        if (rd_idx[13:3] == clo_pkg::IDX_BUF_HI && rd_idx[2:0] < 3'(clo_pkg::NUM_BUF)) begin
          rd_word = {24'h0, buf_reg[rd_idx[2:0]]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= clo_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? clo_pkg::RESP_OKAY : clo_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================
  // Error counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tec_reg <= 8'h00;
      rec_reg <= 8'h00;
    end else if (listen) begin
      tec_reg <= 8'h00;
      rec_reg <= 8'h00;
    end else begin
      if (tx_error_pulse && tec_reg != clo_pkg::CNT_MAX) begin
        tec_reg <= tec_reg + 8'h01;
      end
      if (rx_error_pulse && rec_reg != clo_pkg::CNT_MAX) begin
        rec_reg <= rec_reg + 8'h01;
      end
    end
  end

  // ==========================================
  // Transmit pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      can_tx_reg <= 1'b1;
    end else begin
      can_tx_reg <= listen ? 1'b1 : core_tx_bit;
    end
  end
  assign can_tx = can_tx_reg;

  // ==========================================
  // Acceptance
  always_comb begin
    if (listen) begin
      accept = frame_error | (|match);
    end else if (frame_error) begin
      accept = 1'b0;
    end else begin
      accept = (mode_reg[clo_pkg::RXM_LSB +: 2] == clo_pkg::RXM_ALL_VALID) | (|match);
    end
  end

  // ==========================================
  // Receive buffer
  assign in_frame.err  = frame_error;
  assign in_frame.dlc  = frame_dlc;
  assign in_frame.id   = frame_id;
  assign in_frame.data = frame_data;
  assign in_if.valid   = frame_valid & accept;
  assign in_if.payload = in_frame;
  assign frame_ready   = in_if.ready;

  clo_frame_buffer #(.W(FW)) u_buffer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .in_port  (in_if),
    .out_port (out_if)
  );

  assign out_if.ready = rx_ready;
  assign out_frame    = out_if.payload;
  assign rx_valid     = out_if.valid;
  assign rx_id        = out_frame.id;
  assign rx_dlc       = out_frame.dlc;
  assign rx_data      = out_frame.data;
  assign rx_error     = out_frame.err;
endmodule
`default_nettype wire

// [clo_pkg.sv]
`default_nettype none
package clo_pkg;
  // ==========================================
  // Bus geometry
  localparam int         ADDR_W        = 16;
  localparam int         IDX_W         = 14;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ==========================================
  // Register indices, byte address is four times the index
  localparam logic [13:0] IDX_MODE     = 14'h0000;
  localparam logic [13:0] IDX_STATUS   = 14'h0001;
  localparam logic [13:0] IDX_ERRCNT   = 14'h0002;
  localparam logic [13:0] IDX_ECTRL    = 14'h0003;
  localparam logic [13:0] IDX_MASK     = 14'h0004;
  localparam logic [13:0] IDX_FILT     = 14'h0005;
  localparam logic [13:0] IDX_WINDOW   = 14'h0006;
  localparam logic [10:0] IDX_BUF_HI   = 11'h001;
  localparam logic [13:0] IDX_FEN_LO   = 14'h0E46;
  localparam logic [13:0] IDX_FEN_HI   = 14'h0E47;
  // ==========================================
  // Field positions
  localparam int MODE_REQ_LSB = 5;
  localparam int RXM_LSB      = 0;
  localparam int EWSEL_LSB    = 0;
  localparam int EMODE_LSB    = 6;
  localparam int FILT_IDX_LSB = 24;
  localparam int BUF_DIR_BIT  = 7;
  // ==========================================
  // Encodings
  localparam logic [2:0] MODE_LISTEN   = 3'h3;
  localparam logic [1:0] RXM_ALL_VALID = 2'h3;
  localparam logic [1:0] EMODE_ENH     = 2'h1;
  localparam logic [1:0] EMODE_FIFO    = 2'h2;
  localparam logic [4:0] WIN_BUF_FIRST = 5'h12;
  localparam logic [4:0] WIN_BUF_LAST  = 5'h17;
  localparam int         NUM_BUF       = 6;
  localparam int         NUM_FILT      = 16;
  localparam logic [7:0] CNT_MAX       = 8'hFF;
  // ==========================================
  // Reset values
  localparam logic [7:0]  MODE_RST     = 8'h80;
  localparam logic [7:0]  ECTRL_RST    = 8'h00;
  localparam logic [10:0] MASK_RST     = 11'h7FF;
  localparam logic [10:0] FILT_RST     = 11'h000;
  localparam logic [7:0]  FEN_LO_RST   = 8'h01;
  localparam logic [7:0]  FEN_HI_RST   = 8'h00;
  localparam logic [7:0]  BUF_RST      = 8'h00;
  // ==========================================
  // Frame record
  typedef struct packed {
    logic        err;
    logic [3:0]  dlc;
    logic [10:0] id;
    logic [63:0] data;
  } clo_frame_type;
endpackage
`default_nettype wire

// [clo_stream_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface clo_stream_if #(parameter int W = 80);
  logic         valid;
  logic         ready;
  logic [W-1:0] payload;
  modport src (output valid, output payload, input ready);
  modport snk (input valid, input payload, output ready);
endinterface
`default_nettype wire

// [clo_frame_buffer.sv]
`timescale 1ns/10ps
`default_nettype none
module clo_frame_buffer #(
  parameter int W = 80
) (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  clo_stream_if.snk   in_port,
  clo_stream_if.src   out_port
);
  // ==========================================
  // Two entries, head drives the output
  logic [W-1:0] head_reg;
  logic [W-1:0] tail_reg;
  logic         head_valid_reg;
  logic         tail_free_reg;
  logic         push;
  logic         pop;

  if (W < 1) begin : g_width_check
    $error("buffer width must be positive");
  end

  assign push             = in_port.valid & tail_free_reg;
  assign pop              = head_valid_reg & out_port.ready;
  assign in_port.ready    = tail_free_reg;
  assign out_port.valid   = head_valid_reg;
  assign out_port.payload = head_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      head_valid_reg <= 1'b0;
      tail_free_reg  <= 1'b1;
      head_reg       <= '0;
      tail_reg       <= '0;
    end else if (pop) begin
      if (!tail_free_reg) begin
        head_reg      <= tail_reg;
        tail_free_reg <= 1'b1;
      end else begin
        head_valid_reg <= push;
        if (push) begin
          head_reg <= in_port.payload;
        end
      end
    end else if (push) begin
      if (!head_valid_reg) begin
        head_reg       <= in_port.payload;
        head_valid_reg <= 1'b1;
      end else begin
        tail_reg      <= in_port.payload;
        tail_free_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [clo_listen_window_end.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [clo_listen_window_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module clo_listen_window_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        core_tx_bit,
  input wire logic        can_tx,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [10:0] rx_id,
  input wire logic        rx_error
);
  // ==========================================
  // Shadow of bus addresses and mode
  logic [15:0] aw_q;
  logic [15:0] ar_q;
  logic [7:0]  w_q;
  logic        listen_q;
  function automatic logic mapped(input logic [15:0] a);
    logic [13:0] i;
    i = a[15:2];
    return i <= 14'h0006 || (i >= 14'h0008 && i <= 14'h000D) ||
           i == clo_pkg::IDX_FEN_LO || i == clo_pkg::IDX_FEN_HI;
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 16'h0000;
      ar_q     <= 16'h0000;
      w_q      <= 8'h00;
      listen_q <= 1'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
      if ($rose(s_axi_bvalid) && aw_q[15:2] == clo_pkg::IDX_MODE) begin
        listen_q <= w_q[7:5] == clo_pkg::MODE_LISTEN;
      end
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  bresp_map_a: assert property (s_axi_bvalid |-> s_axi_bresp ==
    (mapped(aw_q) ? clo_pkg::RESP_OKAY : clo_pkg::RESP_SLVERR)) else $error("bad bresp");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  rresp_map_a: assert property (s_axi_rvalid |-> (mapped(ar_q) ?
    s_axi_rresp == clo_pkg::RESP_OKAY : s_axi_rresp == clo_pkg::RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("bad rresp");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  tx_silent_a: assert property (listen_q |-> can_tx)
    else $error("bus driven while listening");
  tx_follow_a: assert property (!listen_q && $past(!listen_q) && $past(aresetn) |->
    can_tx == $past(core_tx_bit)) else $error("tx not following core");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable({rx_id, rx_error}))
    else $error("frame dropped");
endmodule
bind clo_listen_window clo_listen_window_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .core_tx_bit, .can_tx, .rx_valid, .rx_ready, .rx_id, .rx_error);
`default_nettype wire

// [clo_can_node.sv]
`timescale 1ns/10ps
`default_nettype none
module clo_can_node (
  input  wire logic   aclk,
  input  wire logic   frame_ready,
  output logic        frame_valid,
  output logic [10:0] frame_id,
  output logic [3:0]  frame_dlc,
  output logic [63:0] frame_data,
  output logic        frame_error
);
  // ==========================================
  // Frame source of the other bus nodes
  initial begin
    frame_valid = 1'h0;
    frame_id    = 11'h000;
    frame_dlc   = 4'h0;
    frame_data  = 64'h0;
    frame_error = 1'h0;
  end
  task automatic offer(input logic [10:0] id, input logic err);
    @(posedge aclk);
    frame_valid <= 1'h1;
    frame_id    <= id;
    frame_dlc   <= 4'h8;
    frame_data  <= {16{id[3:0]}};
    frame_error <= err;
    do @(posedge aclk); while (!frame_ready);
    frame_valid <= 1'h0;
    frame_id    <= ~id;
    frame_data  <= ~frame_data;
    frame_error <= ~err;
  endtask
endmodule
`default_nettype wire

// [clo_listen_window_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); \
  end \
end
module clo_listen_window_tb;
  // ==========================================
  // Stimulus and observed signals
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        core_tx_bit = 1'h1;
  logic        tx_error_pulse = 1'h0;
  logic        rx_error_pulse = 1'h0;
  logic        rx_ready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        frame_valid, frame_ready, frame_error, can_tx, rx_valid, rx_error;
  logic [10:0] frame_id, rx_id;
  logic [3:0]  frame_dlc, rx_dlc;
  logic [63:0] frame_data, rx_data;
  int          bad_count = 0;
  int          total_checks = 0;
  clo_listen_window uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .frame_valid, .frame_ready, .frame_id, .frame_dlc, .frame_data,
    .frame_error, .core_tx_bit, .tx_error_pulse, .rx_error_pulse, .can_tx, .rx_valid, .rx_ready,
    .rx_id, .rx_dlc, .rx_data, .rx_error);
  clo_can_node node (.aclk, .frame_ready, .frame_valid, .frame_id, .frame_dlc, .frame_data,
    .frame_error);
  always #4 aclk = ~aclk;
  // ==========================================
  // Bus and frame helpers
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic w(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK("write resp", 2'h0, r)
  endtask
  task automatic rchk(input logic [15:0] a, input logic [33:0] e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    `CHK("read", e, {s_axi_rresp, s_axi_rdata})
    s_axi_rready <= 1'h0;
  endtask
  task automatic pulse_errors;
    @(posedge aclk);
    tx_error_pulse <= 1'h1;
    rx_error_pulse <= 1'h1;
    @(posedge aclk);
    tx_error_pulse <= 1'h0;
    rx_error_pulse <= 1'h0;
  endtask
  task automatic pop(input logic [10:0] id, input logic err);
    `CHK("rx frame", {err, id, 4'h8, {16{id[3:0]}}}, {rx_error, rx_id, rx_dlc, rx_data})
    rx_ready <= 1'h1;
    @(posedge aclk);
    rx_ready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic send(input logic [10:0] id, input logic err, input logic exp);
    node.offer(id, err);
    repeat (2) @(posedge aclk);
    `CHK("rx valid", exp, rx_valid)
    if (exp) pop(id, err);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [1:0] r;
    rchk(16'h0000, 34'h000000080);
    rchk(16'h3918, 34'h000000001);
    rchk(16'h391C, 34'h000000000);
    rchk(16'h0040, 34'h200000000);
    wr(16'h0044, 32'h000000FF, r);
    `CHK("unmapped write", 2'h2, r)
    w(16'h391C, 32'h000000A5);
    rchk(16'h391C, 34'h0000000A5);
  endtask
  task automatic t_normal;
    @(posedge aclk);
    core_tx_bit <= 1'h0;
    repeat (2) @(posedge aclk);
    `CHK("tx follows", 1'h0, can_tx)
    pulse_errors;
    rchk(16'h0008, 34'h000000101);
    send(11'h123, 1'h1, 1'h0);
  endtask
  task automatic t_listen;
    w(16'h0000, 32'h00000060);
    rchk(16'h0004, 34'h000000060);
    rchk(16'h0008, 34'h000000000);
    pulse_errors;
    rchk(16'h0008, 34'h000000000);
    `CHK("tx silent", 1'h1, can_tx)
    send(11'h123, 1'h0, 1'h0);
    send(11'h123, 1'h1, 1'h1);
    send(11'h000, 1'h0, 1'h1);
    w(16'h0000, 32'h00000063);
    send(11'h123, 1'h0, 1'h0);
    send(11'h124, 1'h1, 1'h1);
    w(16'h0010, 32'h0);
    send(11'h5A5, 1'h0, 1'h1);
    w(16'h3918, 32'h0);
    w(16'h391C, 32'h0);
    send(11'h5A5, 1'h0, 1'h0);
    send(11'h5A6, 1'h1, 1'h1);
  endtask
  task automatic t_buffer;
    node.offer(11'h011, 1'h1);
    node.offer(11'h022, 1'h1);
    repeat (2) @(posedge aclk);
    `CHK("buffer full", 1'h0, frame_ready)
    pop(11'h011, 1'h1);
    pop(11'h022, 1'h1);
    `CHK("buffer empty", 1'h0, rx_valid)
  endtask
  task automatic t_window;
    logic [15:0] ba;
    logic [7:0]  v;
    for (int n = 0; n < 6; n++) begin
      ba = 16'h0020 + 16'(4 * n);
      v = 8'h40 + 8'(n) + ((n % 2 == 1) ? 8'h80 : 8'h00);
      w(ba, {24'h0, v});
      w(16'h000C, 32'(18 + n));
      rchk(16'h0018, 34'h000000000);
      w(16'h0018, 32'h00000001);
      rchk(ba, {26'h0, v});
      w(16'h000C, 32'((1 + n % 2) * 64 + 18 + n));
      rchk(16'h0018, {26'h0, v});
      w(16'h0018, {24'h0, ~v});
      rchk(ba, {26'h0, ~v});
    end
    w(16'h000C, 32'h00000051);
    rchk(16'h0018, 34'h000000000);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_normal;
    t_listen;
    t_buffer;
    t_window;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
